// ---- src/rco_regs.svh ----
// Function
// - Reads of the control register always return its contents, and writes are dropped while write protection is active.
// - The control register at offset 0Fh holds the alarm source, the update period and the countdown timer settings.
// - The timer repeat select bit chooses single mode or repeat mode for the countdown timer.
// - In single mode the enabled countdown stops when it reaches zero and the block clears the countdown enable bit itself.
// - In repeat mode the countdown reloads at zero and keeps counting, giving periodic events.
// - Bit 6 is not implemented and always reads as zero.
// - An alarm source select of zero, the reset value, makes the alarm compare against the weekday.
`ifndef RCO_REGS_SVH
`define RCO_REGS_SVH

// ****************************************************************
// Register map
// ****************************************************************
`define RCO_ADDR_CONTROL_ONE 8'h0F
`define RCO_RESET_CONTROL_ONE 8'h00

// ****************************************************************
// Field positions of control_one
// ****************************************************************
`define RCO_BIT_TIMER_REPEAT 7
`define RCO_BIT_UNUSED 6
`define RCO_BIT_ALARM_SOURCE 5
`define RCO_BIT_UPDATE_PERIOD 4
`define RCO_BIT_REFRESH_DISABLE 3
`define RCO_BIT_COUNTDOWN_EN 2
`define RCO_CLK_SEL_MSB 1
`define RCO_CLK_SEL_LSB 0

// ****************************************************************
// Default source divisions, in ref_clk cycles per decrement
// ****************************************************************
`define RCO_DIV_SEL0 40'h000000EE6B
`define RCO_DIV_SEL1 40'h00003B9ACA
`define RCO_DIV_SEL2 40'h000EE6B280
`define RCO_DIV_SEL3 40'h037E11D600

`endif

// ---- src/rco_pkg.sv ----
package rco_pkg;

   // Countdown source selection codes
   typedef enum logic [1:0] {
      RCO_SRC_0 = 2'h0,
      RCO_SRC_1 = 2'h1,
      RCO_SRC_2 = 2'h2,
      RCO_SRC_3 = 2'h3
   } rco_clk_sel_t;

   // Alarm compare target
   typedef enum logic {
      RCO_ALARM_WEEKDAY = 1'h0,
      RCO_ALARM_DATE = 1'h1
   } rco_alarm_src_t;

   // Countdown mode
   typedef enum logic {
      RCO_MODE_SINGLE = 1'h0,
      RCO_MODE_REPEAT = 1'h1
   } rco_mode_t;

endpackage

// ---- src/rco_tick_div.sv ----
`timescale 1ns/1ps
`include "rco_regs.svh"

module rco_tick_div
   import rco_pkg::*;
#(
   parameter logic [39:0] DIV0 = `RCO_DIV_SEL0,
   parameter logic [39:0] DIV1 = `RCO_DIV_SEL1,
   parameter logic [39:0] DIV2 = `RCO_DIV_SEL2,
   parameter logic [39:0] DIV3 = `RCO_DIV_SEL3
) (
   input wire logic ref_clk,          // System clock
   input wire logic rst_b,            // Async reset, active low
   input wire logic run,              // Divider runs while high
   input wire rco_clk_sel_t sel,      // Source rate select
   output logic tick                  // One-cycle decrement enable
);

   logic [39:0] cnt_ff;
   logic [39:0] nxt_cnt;
   logic [39:0] limit;

   // ****************************************************************
   // Division lookup
   // ****************************************************************
   function automatic logic [39:0] pick_div(input rco_clk_sel_t s);
      logic [39:0] d;
      d = DIV0;
      unique case (s)
         RCO_SRC_0: d = DIV0;
         RCO_SRC_1: d = DIV1;
         RCO_SRC_2: d = DIV2;
         RCO_SRC_3: d = DIV3;
      endcase
      return d;
   endfunction

   assign limit = pick_div(sel);

   always_comb begin
      nxt_cnt = cnt_ff + 40'h0000000001;
      if (!run || nxt_cnt >= limit) begin
         nxt_cnt = 40'h0000000000;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         cnt_ff <= 40'h0000000000;
      end else begin
         cnt_ff <= nxt_cnt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         tick <= 1'b0;
      end else begin
         tick <= run && (cnt_ff + 40'h0000000001 >= limit);
      end
   end

endmodule

// ---- src/rco_control_one.sv ----
`timescale 1ns/1ps
`include "rco_regs.svh"

module rco_control_one
   import rco_pkg::*;
#(
   parameter int CNT_W = 12,
   parameter logic [39:0] DIV0 = `RCO_DIV_SEL0,
   parameter logic [39:0] DIV1 = `RCO_DIV_SEL1,
   parameter logic [39:0] DIV2 = `RCO_DIV_SEL2,
   parameter logic [39:0] DIV3 = `RCO_DIV_SEL3
) (
   input wire logic ref_clk,                  // System clock
   input wire logic rst_b,                    // Async reset, active low
   input wire logic [7:0] reg_addr,           // Register address
   input wire logic reg_wr,                   // Write strobe
   input wire logic reg_rd,                   // Read strobe
   input wire logic [7:0] reg_wdata,          // Write data
   input wire logic write_protect,            // Password lock active
   input wire logic [CNT_W-1:0] timer_reload, // Countdown start value
   output logic [7:0] reg_rdata_ff,           // Read data
   output logic reg_rvalid_ff,                // Read data valid pulse
   output logic wr_rejected_ff,               // Write dropped pulse
   output logic timer_repeat_select_ff,       // Repeat mode
   output logic alarm_source_select_ff,       // Alarm source, 0 weekday
   output logic update_period_select_ff,      // Update period select
   output logic config_refresh_disable_ff,    // Refresh disable
   output logic countdown_enable_ff,          // Countdown running
   output logic [1:0] countdown_clock_select_ff, // Countdown rate
   output logic [CNT_W-1:0] countdown_value_ff,  // Current count
   output logic countdown_event_ff            // Count reached zero pulse
);

   logic wr_hit;
   logic wr_ok;
   logic rd_hit;
   logic start;
   logic tick;
   logic at_zero;
   logic single_stop;
   logic [7:0] ctrl_word;
   logic [CNT_W-1:0] one_cnt;

   assign one_cnt = {{(CNT_W-1){1'b0}}, 1'b1};

   // ****************************************************************
   // Register access decode
   // ****************************************************************
   assign wr_hit = reg_wr && (reg_addr == `RCO_ADDR_CONTROL_ONE);
   assign wr_ok = wr_hit && !write_protect;
   assign rd_hit = reg_rd && (reg_addr == `RCO_ADDR_CONTROL_ONE);

   assign ctrl_word = {
      timer_repeat_select_ff,
      1'b0,
      alarm_source_select_ff,
      update_period_select_ff,
      config_refresh_disable_ff,
      countdown_enable_ff,
      countdown_clock_select_ff
   };

   // ****************************************************************
   // Countdown control terms
   // ****************************************************************
   assign start = wr_ok && reg_wdata[`RCO_BIT_COUNTDOWN_EN] &&
                  !countdown_enable_ff;
   assign at_zero = countdown_enable_ff && tick &&
                    (countdown_value_ff <= one_cnt);
   assign single_stop = at_zero &&
      (rco_mode_t'(timer_repeat_select_ff) == RCO_MODE_SINGLE);

   // ****************************************************************
   // Configuration fields
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         timer_repeat_select_ff <= 1'b0;
         alarm_source_select_ff <= RCO_ALARM_WEEKDAY;
         update_period_select_ff <= 1'b0;
         config_refresh_disable_ff <= 1'b0;
         countdown_clock_select_ff <= 2'h0;
      end else if (wr_ok) begin
         timer_repeat_select_ff <= reg_wdata[`RCO_BIT_TIMER_REPEAT];
         alarm_source_select_ff <= reg_wdata[`RCO_BIT_ALARM_SOURCE];
         update_period_select_ff <= reg_wdata[`RCO_BIT_UPDATE_PERIOD];
         config_refresh_disable_ff <= reg_wdata[`RCO_BIT_REFRESH_DISABLE];
         countdown_clock_select_ff <=
            reg_wdata[`RCO_CLK_SEL_MSB:`RCO_CLK_SEL_LSB];
      end
   end

   // ****************************************************************
   // Countdown enable, software write wins over self clear
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         countdown_enable_ff <= 1'b0;
      end else if (wr_ok) begin
         countdown_enable_ff <= reg_wdata[`RCO_BIT_COUNTDOWN_EN];
      end else if (single_stop) begin
         countdown_enable_ff <= 1'b0;
      end
   end

   // ****************************************************************
   // Countdown value
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         countdown_value_ff <= {CNT_W{1'b0}};
      end else if (start) begin
         countdown_value_ff <= timer_reload;
      end else if (at_zero) begin
         if (single_stop) begin
            countdown_value_ff <= {CNT_W{1'b0}};
         end else begin
            countdown_value_ff <= timer_reload;
         end
      end else if (countdown_enable_ff && tick) begin
         countdown_value_ff <= countdown_value_ff - one_cnt;
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         countdown_event_ff <= 1'b0;
      end else begin
         countdown_event_ff <= at_zero && !wr_ok;
      end
   end

   // ****************************************************************
   // Read path and write refusal
   // ****************************************************************
   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         reg_rdata_ff <= `RCO_RESET_CONTROL_ONE;
         reg_rvalid_ff <= 1'b0;
      end else begin
         reg_rvalid_ff <= rd_hit;
         if (rd_hit) begin
            reg_rdata_ff <= ctrl_word;
         end
      end
   end

   always_ff @(posedge ref_clk or negedge rst_b) begin
      if (!rst_b) begin
         wr_rejected_ff <= 1'b0;
      end else begin
         wr_rejected_ff <= wr_hit && write_protect;
      end
   end

   // ****************************************************************
   // Decrement rate
   // ****************************************************************
   rco_tick_div #(
      .DIV0(DIV0),
      .DIV1(DIV1),
      .DIV2(DIV2),
      .DIV3(DIV3)
   ) u_tick (
      .ref_clk(ref_clk),
      .rst_b(rst_b),
      .run(countdown_enable_ff),
      .sel(rco_clk_sel_t'(countdown_clock_select_ff)),
      .tick(tick)
   );

endmodule

// ---- test/rco_control_one_properties.sv ----
`timescale 1ns/1ps
// ****
// Checker
// ****
module rco_control_one_properties (
   input wire logic ref_clk, // Clock
   input wire logic rst_b, // Reset
   input wire logic [7:0] reg_addr, // Address
   input wire logic reg_wr, // Write
   input wire logic reg_rd, // Read
   input wire logic [7:0] reg_wdata, // Write data
   input wire logic write_protect, // Lock
   input wire logic [7:0] reg_rdata_ff, // Read data
   input wire logic reg_rvalid_ff, // Read valid
   input wire logic wr_rejected_ff, // Reject
   input wire logic timer_repeat_select_ff, // Repeat
   input wire logic alarm_source_select_ff, // Alarm
   input wire logic countdown_enable_ff, // Enable
   input wire logic [1:0] countdown_clock_select_ff, // Rate
   input wire logic countdown_event_ff // Event
);
   default clocking @(posedge ref_clk); endclocking
   default disable iff (!rst_b);
   logic hit;
   assign hit = reg_addr == 8'h0F;
   read_answer_a: assert property (reg_rd && hit |=> reg_rvalid_ff)
      else $error("read not answered");
   stray_valid_a: assert property (!(reg_rd && hit) |=> !reg_rvalid_ff)
      else $error("valid without read");
   reject_hold_a: assert property (reg_wr && hit && write_protect |=>
      wr_rejected_ff && $stable(alarm_source_select_ff)
      && $stable(countdown_clock_select_ff)) else $error("bad reject");
   bit6_zero_a: assert property (reg_rvalid_ff |-> !reg_rdata_ff[6])
      else $error("bit 6 set");
   write_fields_a: assert property (reg_wr && hit && !write_protect |=>
      timer_repeat_select_ff == $past(reg_wdata[7])
      && alarm_source_select_ff == $past(reg_wdata[5]))
      else $error("fields not written");
   rate_write_a: assert property (reg_wr && hit && !write_protect |=>
      countdown_clock_select_ff == $past(reg_wdata[1:0]))
      else $error("rate not written");
   single_stop_a: assert property (countdown_event_ff &&
      !timer_repeat_select_ff |-> ##[0:1] !countdown_enable_ff)
      else $error("single mode did not stop");
   repeat_keep_a: assert property (countdown_event_ff &&
      timer_repeat_select_ff |-> countdown_enable_ff)
      else $error("repeat mode stopped");
endmodule

bind rco_control_one rco_control_one_properties
   rco_control_one_properties_i (.ref_clk, .rst_b, .reg_addr, .reg_wr,
   .reg_rd, .reg_wdata, .write_protect, .reg_rdata_ff, .reg_rvalid_ff,
   .wr_rejected_ff, .timer_repeat_select_ff, .alarm_source_select_ff,
   .countdown_enable_ff, .countdown_clock_select_ff, .countdown_event_ff);

// ---- test/tb_top.sv ----
`timescale 1ns/1ps
`define CHK(n, e, a) begin tests_run++; if ((a) !== (e)) begin \
   num_errors++; $display("CHECK FAILED %s exp %0h got %0h", n, e, a); \
   end end
// ****
// Bench
// ****
module tb_top;
   import rco_pkg::*;
   logic ref_clk = 1'b0;
   logic rst_b = 1'b0;
   logic [7:0] reg_addr = 8'h00;
   logic reg_wr = 1'b0;
   logic reg_rd = 1'b0;
   logic [7:0] reg_wdata = 8'h00;
   logic write_protect = 1'b0;
   logic [11:0] timer_reload = 12'h000;
   logic [7:0] reg_rdata_ff, d;
   logic reg_rvalid_ff, wr_rejected_ff, timer_repeat_select_ff, v, r;
   logic alarm_source_select_ff, update_period_select_ff, countdown_event_ff;
   logic config_refresh_disable_ff, countdown_enable_ff;
   logic [1:0] countdown_clock_select_ff;
   logic [11:0] countdown_value_ff;
   int num_errors = 0;
   int tests_run = 0;
   int n;
   always #2 ref_clk = ~ref_clk;
   rco_control_one #(.DIV0(40'h4), .DIV1(40'h6), .DIV2(40'h8),
      .DIV3(40'hA)) rco_control_one_i (.ref_clk, .rst_b, .reg_addr,
      .reg_wr, .reg_rd, .reg_wdata, .write_protect, .timer_reload,
      .reg_rdata_ff, .reg_rvalid_ff, .wr_rejected_ff,
      .timer_repeat_select_ff, .alarm_source_select_ff,
      .update_period_select_ff, .config_refresh_disable_ff,
      .countdown_enable_ff, .countdown_clock_select_ff,
      .countdown_value_ff, .countdown_event_ff);
   task automatic wr(input logic [7:0] a, input logic [7:0] x,
         input logic p);
      @(negedge ref_clk);
      reg_addr = a;
      reg_wdata = x;
      write_protect = p;
      reg_wr = 1'b1;
      @(negedge ref_clk);
      reg_wr = 1'b0;
      write_protect = 1'b0;
      r = wr_rejected_ff;
   endtask
   task automatic rd(input logic [7:0] a);
      @(negedge ref_clk);
      reg_addr = a;
      reg_rd = 1'b1;
      @(negedge ref_clk);
      reg_rd = 1'b0;
      d = reg_rdata_ff;
      v = reg_rvalid_ff;
   endtask
   task automatic wait_ev();
      v = 1'b0;
      for (n = 1; n < 300 && !v; n++) begin
         @(negedge ref_clk);
         v = countdown_event_ff;
      end
      n--;
   endtask
   task automatic final_report();
      $display("comparisons %0d mismatches %0d", tests_run, num_errors);
      if (num_errors == 0 && tests_run > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask
   initial begin
      #20000;
      num_errors++;
      final_report();
   end
   initial begin
      repeat (6) @(negedge ref_clk);
      rst_b = 1'b1;
      rd(8'h0F);
      `CHK("reset", 8'h00, d)
      wr(8'h0F, 8'hFB, 1'b0);
      rd(8'h0F);
      `CHK("bit6", 8'hBB, d)
      `CHK("rate", 2'h3, countdown_clock_select_ff)
      `CHK("period sel", 1'b1, update_period_select_ff)
      `CHK("refresh", 1'b1, config_refresh_disable_ff)
      wr(8'h0F, 8'h00, 1'b1);
      `CHK("reject", 1'b1, r)
      wr(8'h10, 8'h00, 1'b0);
      rd(8'h0F);
      `CHK("locked", 8'hBB, d)
      rd(8'h0E);
      `CHK("miss", 1'b0, v)
      $display("register test done");
      timer_reload = 12'h002;
      wr(8'h0F, 8'h04, 1'b0);
      `CHK("load", 12'h002, countdown_value_ff)
      wait_ev();
      @(negedge ref_clk);
      `CHK("stop", 1'b0, countdown_enable_ff)
      `CHK("zero", 12'h000, countdown_value_ff)
      $display("single test done");
      timer_reload = 12'h003;
      wr(8'h0F, 8'h85, 1'b0);
      wait_ev();
      wait_ev();
      `CHK("period", 18, n)
      `CHK("run", 1'b1, countdown_enable_ff)
      wr(8'h0F, 8'h00, 1'b0);
      $display("repeat test done");
      timer_reload = 12'h001;
      wr(8'h0F, 8'h06, 1'b0);
      wait_ev();
      `CHK("event", 1'b1, v)
      `CHK("rate two", 9, n)
      wr(8'h0F, 8'h07, 1'b0);
      wait_ev();
      `CHK("rate three", 11, n)
      $display("rate test done");
      final_report();
   end
endmodule
